// [pkg/cmsd_pkg.sv]
`default_nettype none
package cmsd_pkg;

  // Addressing modes presented by the core with each access
  typedef enum logic [2:0] {
    CMSD_MODE_REGISTER,
    CMSD_MODE_DIRECT,
    CMSD_MODE_INDIRECT,
    CMSD_MODE_IMMEDIATE,
    CMSD_MODE_BIT,
    CMSD_MODE_EXT_DIRECT,
    CMSD_MODE_EXT_INDIRECT,
    CMSD_MODE_CODE_INDIRECT
  } cmsd_mode_t;

  // Resource an access resolves to
  typedef enum logic [2:0] {
    CMSD_TGT_RAM,
    CMSD_TGT_SFR,
    CMSD_TGT_CFG,
    CMSD_TGT_EXTENDED_INTERNAL_RAM,
    CMSD_TGT_CODE,
    CMSD_TGT_NONE
  } cmsd_tgt_t;

  // Space boundaries
  localparam logic [7:0] CMSD_UPPER_BASE = 8'h80;
  localparam logic [7:0] CMSD_BITRAM_BASE = 8'h20;
  localparam logic [7:0] CMSD_CFG_ADDR = 8'hAF;
  localparam logic [7:0] CMSD_EXTENDED_INTERNAL_RAM_PAGE = 8'h00;

  // Configuration field after reset: extended RAM disabled
  localparam logic [1:0] CMSD_CFG_RESET = 2'h0;

  // Core clock cycles per access, by addressing mode
  localparam logic [2:0] CMSD_LAT_REGISTER = 3'h1;
  localparam logic [2:0] CMSD_LAT_DIRECT = 3'h2;
  localparam logic [2:0] CMSD_LAT_INDIRECT = 3'h2;
  localparam logic [2:0] CMSD_LAT_IMMEDIATE = 3'h2;
  localparam logic [2:0] CMSD_LAT_BIT = 3'h2;
  localparam logic [2:0] CMSD_LAT_EXT = 3'h4;
  localparam logic [2:0] CMSD_LAT_CODE = 3'h4;

endpackage
`default_nettype wire

// [rtl/cmsd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RULE_01) 256-byte general RAM; upper 128 addresses shared with SFRs by mode.
// (RULE_02) Addresses 0x00-0x7F reach RAM under direct or indirect addressing.
// (RULE_03) RAM 0x80-0xFF only by indirect; indirect never selects an SFR.
// (RULE_04) Direct access at 0x80-0xFF goes to the SFR at that address.
// (RULE_05) Bit address 8k+n is bit n of RAM byte 0x20+k.
// (RULE_06) Bit read and modify also on bit-addressable SFRs.
// (RULE_07) 256-byte extended RAM at 0x0000-0x00FF, extended modes only, nothing external.
// (RULE_08) Extended RAM enabled by writing 01 to low bits of config at 0xAF.
// (RULE_09) No external code or data path; every access resolves on chip.
// (RULE_10) 16 kB code flash; data reads from it only by code indirect.
// (RULE_11) Immediate literal fetched from program memory, slower than register ops.
// (RULE_12) Register-to-register direct access completes in fewest cycles.
// (RULE_13) Extended move enabled when either config low bit is 1.
// (RULE_14) Four banks of eight registers in first 32 RAM bytes, bank bits select.
// (RULE_15) Disabled extended RAM reads zero and ignores writes.
module cmsd_decoder #(
  parameter int CODE_AW = 14
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic bank_select_hi_i,
  input wire logic bank_select_lo_i,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic [7:0] code_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic sfr_sel_o,
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic [7:0] sfr_wdata_o,
  output logic [CODE_AW-1:0] code_addr_o,
  output logic extended_internal_ram_enable_o
);

  typedef enum logic {CMSD_IDLE, CMSD_BUSY} cmsd_state_t;

  cmsd_state_t state_ff;
  cmsd_pkg::cmsd_tgt_t tgt_ff;
  cmsd_pkg::cmsd_tgt_t nxt_tgt;
  logic [7:0] ba_ff;
  logic [7:0] nxt_ba;
  logic [2:0] bit_ff;
  logic bitop_ff;
  logic wr_ff;
  logic [7:0] wdata_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_lat;
  logic [1:0] cfg_ff;
  logic [7:0] ram_ff [256];
  logic [7:0] extended_internal_ram_ff [256];
  logic [7:0] cur_byte;
  logic [7:0] mod_byte;
  logic accept;
  logic finish;
  logic extended_internal_ram_en;
  cmsd_pkg::cmsd_mode_t mode;

  assign mode = cmsd_pkg::cmsd_mode_t'(mode_i);
  assign accept = req_i && (state_ff == CMSD_IDLE);
  assign finish = (state_ff == CMSD_BUSY) && (cnt_ff == 3'h1);
  assign extended_internal_ram_en = |cfg_ff; // [RULE_13] [RULE_08]

  //////////////////////////////////////////////////////////////////////////////
  // Address decode of the incoming request

  // Decoded at accept and latched, so the SFR and code ports settle early
  always_comb begin
    nxt_tgt = cmsd_pkg::CMSD_TGT_NONE;
    nxt_ba = addr_i[7:0];
    nxt_lat = cmsd_pkg::CMSD_LAT_DIRECT;
    case (mode)
      cmsd_pkg::CMSD_MODE_REGISTER: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_RAM;
        nxt_ba = {3'h0, bank_select_hi_i, bank_select_lo_i, addr_i[2:0]}; // [RULE_14]
        nxt_lat = cmsd_pkg::CMSD_LAT_REGISTER; // [RULE_12]
      end
      cmsd_pkg::CMSD_MODE_DIRECT: begin
        if (addr_i[7:0] < cmsd_pkg::CMSD_UPPER_BASE) begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_RAM; // [RULE_02]
        end else if (addr_i[7:0] == cmsd_pkg::CMSD_CFG_ADDR) begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_CFG; // [RULE_08]
        end else begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_SFR; // [RULE_04] [RULE_01]
        end
      end
      cmsd_pkg::CMSD_MODE_INDIRECT: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_RAM; // [RULE_02] [RULE_03]
        nxt_lat = cmsd_pkg::CMSD_LAT_INDIRECT;
      end
      cmsd_pkg::CMSD_MODE_IMMEDIATE: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_CODE; // [RULE_11]
        nxt_lat = cmsd_pkg::CMSD_LAT_IMMEDIATE;
      end
      cmsd_pkg::CMSD_MODE_BIT: begin
        nxt_lat = cmsd_pkg::CMSD_LAT_BIT;
        if (addr_i[7]) begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_SFR; // [RULE_06]
          nxt_ba = {addr_i[7:3], 3'h0};
        end else begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_RAM;
          nxt_ba = cmsd_pkg::CMSD_BITRAM_BASE + {4'h0, addr_i[6:3]}; // [RULE_05]
        end
      end
      cmsd_pkg::CMSD_MODE_EXT_DIRECT: begin
        nxt_lat = cmsd_pkg::CMSD_LAT_EXT;
        // Pointer above the internal page finds nothing: no external bus
        if (addr_i[15:8] == cmsd_pkg::CMSD_EXTENDED_INTERNAL_RAM_PAGE) begin
          nxt_tgt = cmsd_pkg::CMSD_TGT_EXTENDED_INTERNAL_RAM; // [RULE_07] [RULE_09]
        end
      end
      cmsd_pkg::CMSD_MODE_EXT_INDIRECT: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_EXTENDED_INTERNAL_RAM; // [RULE_07]
        nxt_lat = cmsd_pkg::CMSD_LAT_EXT;
      end
      cmsd_pkg::CMSD_MODE_CODE_INDIRECT: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_CODE; // [RULE_10]
        nxt_lat = cmsd_pkg::CMSD_LAT_CODE;
      end
      default: begin
        nxt_tgt = cmsd_pkg::CMSD_TGT_NONE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencing

  // One access at a time; the count sets the mode's cycle budget
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= CMSD_IDLE;
      cnt_ff <= 3'h0;
    end else if (accept) begin
      state_ff <= CMSD_BUSY;
      cnt_ff <= nxt_lat; // [RULE_11] [RULE_12]
    end else if (finish) begin
      state_ff <= CMSD_IDLE;
      cnt_ff <= 3'h0;
    end else if (state_ff == CMSD_BUSY) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end

  // Request fields held for the whole access
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_ff <= cmsd_pkg::CMSD_TGT_NONE;
      ba_ff <= 8'h00;
      bit_ff <= 3'h0;
      bitop_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else if (accept) begin
      tgt_ff <= nxt_tgt;
      ba_ff <= nxt_ba;
      bit_ff <= addr_i[2:0];
      bitop_ff <= (mode == cmsd_pkg::CMSD_MODE_BIT);
      // Flash is read-only from this path
      wr_ff <= wr_i && (nxt_tgt != cmsd_pkg::CMSD_TGT_CODE); // [RULE_10]
      wdata_ff <= wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data path

  // Byte currently addressed, and its modified form for writes
  always_comb begin
    case (tgt_ff)
      cmsd_pkg::CMSD_TGT_RAM: cur_byte = ram_ff[ba_ff];
      cmsd_pkg::CMSD_TGT_SFR: cur_byte = sfr_rdata_i;
      cmsd_pkg::CMSD_TGT_CFG: cur_byte = {6'h00, cfg_ff};
      cmsd_pkg::CMSD_TGT_EXTENDED_INTERNAL_RAM: cur_byte = extended_internal_ram_en ? extended_internal_ram_ff[ba_ff] : 8'h00; // [RULE_15]
      cmsd_pkg::CMSD_TGT_CODE: cur_byte = code_rdata_i;
      default: cur_byte = 8'h00;
    endcase
    mod_byte = wdata_ff;
    if (bitop_ff) begin
      mod_byte = cur_byte; // Read-modify-write keeps the other seven bits
      mod_byte[bit_ff] = wdata_ff[0]; // [RULE_05] [RULE_06]
    end
  end

  // General-purpose RAM
  always_ff @(posedge core_clk_i) begin
    if (finish && wr_ff && (tgt_ff == cmsd_pkg::CMSD_TGT_RAM)) begin
      ram_ff[ba_ff] <= mod_byte; // [RULE_01] [RULE_03]
    end
  end

  // Extended RAM; writes dropped while disabled
  always_ff @(posedge core_clk_i) begin
    if (finish && wr_ff && extended_internal_ram_en && (tgt_ff == cmsd_pkg::CMSD_TGT_EXTENDED_INTERNAL_RAM)) begin
      extended_internal_ram_ff[ba_ff] <= mod_byte; // [RULE_07] [RULE_15]
    end
  end

  // Configuration field, reached by a direct write at its SFR address
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= cmsd_pkg::CMSD_CFG_RESET;
    end else if (finish && wr_ff && (tgt_ff == cmsd_pkg::CMSD_TGT_CFG)) begin
      cfg_ff <= mod_byte[1:0]; // [RULE_08]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core-facing answer

  // Bit reads return the selected bit in bit 0
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      busy_o <= 1'b0;
      extended_internal_ram_enable_o <= 1'b0;
    end else begin
      done_o <= finish;
      busy_o <= accept || ((state_ff == CMSD_BUSY) && !finish);
      extended_internal_ram_enable_o <= extended_internal_ram_en;
      if (finish) begin
        rdata_o <= bitop_ff ? {7'h00, cur_byte[bit_ff]} : cur_byte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // SFR and flash ports

  // SFR address is set at accept; the write strobe is raised in the same cycle as done
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_sel_o <= 1'b0;
      sfr_addr_o <= 8'h00;
      sfr_wr_o <= 1'b0;
      sfr_wdata_o <= 8'h00;
    end else begin
      sfr_wr_o <= finish && wr_ff && (tgt_ff == cmsd_pkg::CMSD_TGT_SFR); // [RULE_04]
      if (accept) begin
        sfr_sel_o <= (nxt_tgt == cmsd_pkg::CMSD_TGT_SFR);
        sfr_addr_o <= nxt_ba;
      end else if (sfr_wr_o || (finish && !wr_ff)) begin
        sfr_sel_o <= 1'b0;
      end
      if (finish) begin
        sfr_wdata_o <= mod_byte;
      end
    end
  end

  // Flash address wraps inside the on-chip space, never leaving the chip
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_addr_o <= '0;
    end else if (accept && (nxt_tgt == cmsd_pkg::CMSD_TGT_CODE)) begin
      code_addr_o <= addr_i[CODE_AW-1:0]; // [RULE_09] [RULE_10]
    end
  end

endmodule // cmsd_decoder

`default_nettype wire

// [tb/cmsd_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
// SFR bank and code flash on the far side of the decoder
module cmsd_far_model (
  input wire logic core_clk_i,
  input wire logic sfr_sel_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [13:0] code_addr_i,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] code_rdata_o
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Unselected bank shows inverse data so a stale read never matches
  assign sfr_rdata_o = sfr_sel_i ? mem[sfr_addr_i] : ~mem[sfr_addr_i];
  // Flash content is a fixed function of the address
  assign code_rdata_o = code_addr_i[7:0] ^ {2'h0, code_addr_i[13:8]};
  // Byte lands on the write strobe
  always @(posedge core_clk_i) begin
    if (sfr_wr_i) mem[sfr_addr_i] <= sfr_wdata_i;
  end
endmodule // cmsd_far_model
`default_nettype wire

// [tb/cmsd_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module cmsd_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic sfr_sel_o,
  input wire logic [7:0] sfr_addr_o,
  input wire logic sfr_wr_o,
  input wire logic extended_internal_ram_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Accept happens whenever a request arrives while the decoder is idle
  wire logic acc = req_i && !busy_o;
  wire logic dir = acc && mode_i == 3'h1;
  wire logic want = |wdata_i[1:0];
  ////////////////////////////////////////
  property p_take; acc |=> busy_o; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_reg; acc && mode_i == 3'h0 |=> busy_o ##1 (done_o && !busy_o); endproperty
  a_reg: assert property (p_reg) else $error("register access latency");
  property p_two;
    acc && (mode_i == 3'h1 || mode_i == 3'h2 || mode_i == 3'h3 || mode_i == 3'h4) |=> busy_o [*2] ##1 done_o;
  endproperty
  a_two: assert property (p_two) else $error("two-cycle access latency");
  property p_ext; acc && (mode_i == 3'h5 || mode_i == 3'h6) |=> busy_o [*4] ##1 done_o; endproperty
  a_ext: assert property (p_ext) else $error("extended access latency");
  property p_end; acc |=> ##[1:5] done_o; endproperty
  a_end: assert property (p_end) else $error("access never completed");
  property p_ind; acc && mode_i == 3'h2 |=> !sfr_sel_o [*2]; endproperty
  a_ind: assert property (p_ind) else $error("indirect selected an SFR");
  property p_sfr; dir && addr_i[7] && addr_i[7:0] != 8'hAF |=> sfr_sel_o && sfr_addr_o == $past(addr_i[7:0]);
  endproperty
  a_sfr: assert property (p_sfr) else $error("direct high not routed to SFR");
  property p_low; dir && !addr_i[7] |=> !sfr_sel_o [*2]; endproperty
  a_low: assert property (p_low) else $error("direct low reached SFR");
  property p_wr; sfr_wr_o |-> done_o && sfr_sel_o; endproperty
  a_wr: assert property (p_wr) else $error("SFR write outside completion");
  property p_cfg; dir && addr_i[7:0] == 8'hAF && wr_i |=> ##3 extended_internal_ram_enable_o == $past(want, 4); endproperty
  a_cfg: assert property (p_cfg) else $error("extended RAM enable wrong");
  c_ext: cover property (acc && mode_i == 3'h5);
  c_bit: cover property (acc && mode_i == 3'h4 && addr_i[7]);
  c_cfg: cover property (dir && addr_i[7:0] == 8'hAF && wr_i);
endmodule // cmsd_chk
bind cmsd_decoder cmsd_chk chk (.core_clk_i, .rst_i, .req_i, .mode_i, .addr_i, .wr_i, .wdata_i,
  .busy_o, .done_o, .sfr_sel_o, .sfr_addr_o, .sfr_wr_o, .extended_internal_ram_enable_o);
`default_nettype wire

// [tb/core_data_memory_space_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module core_data_memory_space_decoder_tb;
  logic core_clk_i = 0, rst_i = 1, req_i = 0, wr_i = 0, bhi = 0, blo = 0;
  logic [2:0] mode_i = 0;
  logic [15:0] addr_i = 0;
  logic [7:0] wdata_i = 0, srd, crd, rdata_o, saddr, swd;
  logic [13:0] caddr;
  logic busy_o, done_o, ssel, swr, xen;
  logic [7:0] ram [256], extended_internal_ram [256], sfr [256];
  logic [1:0] cfg = 0;
  int bad_count = 0, total_checks = 0;
  bit hung = 0;
  // Core clock, 40 MHz
  always #12.5 core_clk_i = ~core_clk_i;
  cmsd_decoder dut (.core_clk_i, .rst_i, .req_i, .mode_i, .addr_i, .wr_i, .wdata_i,
    .bank_select_hi_i(bhi), .bank_select_lo_i(blo), .sfr_rdata_i(srd), .code_rdata_i(crd),
    .busy_o, .done_o, .rdata_o, .sfr_sel_o(ssel), .sfr_addr_o(saddr), .sfr_wr_o(swr),
    .sfr_wdata_o(swd), .code_addr_o(caddr), .extended_internal_ram_enable_o(xen));
  cmsd_far_model far (.core_clk_i, .sfr_sel_i(ssel), .sfr_addr_i(saddr), .sfr_wr_i(swr),
    .sfr_wdata_i(swd), .code_addr_i(caddr), .sfr_rdata_o(srd), .code_rdata_o(crd));
  // Reference copy of the far side bank contents
  initial for (int i = 0; i < 256; i++) sfr[i] = 8'(i) ^ 8'h5A;
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One access: reference model first, then the handshake, then compare
  task automatic op(input logic [2:0] m, input logic [15:0] a, input logic w, input logic [7:0] d);
    logic [7:0] e, v;
    logic p;
    int n, t, k;
    // After a hang the remaining accesses are skipped so the run reaches its report
    if (hung) return;
    p = |cfg;
    n = a[7:0];
    t = 0;
    case (m)
      0: n = {bhi, blo, a[2:0]};
      1: t = a[7:0] == 8'hAF ? 2 : a[7];
      3, 7: t = 3;
      4: begin n = a[7] ? {a[7:3], 3'h0} : 8'h20 + a[6:3]; t = a[7]; end
      5, 6: t = cfg != 0 && (m == 6 || a[15:8] == 8'h00) ? 4 : 5;
    endcase
    case (t)
      0: v = ram[n];
      1: v = sfr[n];
      2: v = {6'h00, cfg};
      3: v = a[7:0] ^ {2'h0, a[13:8]};
      4: v = extended_internal_ram[n];
      default: v = 8'h00;
    endcase
    e = m == 4 ? {7'h00, v[a[2:0]]} : v;
    if (m == 4) v[a[2:0]] = d[0];
    else v = d;
    if (w) case (t)
      0: ram[n] = v;
      1: sfr[n] = v;
      2: cfg = v[1:0];
      4: extended_internal_ram[n] = v;
    endcase
    @(posedge core_clk_i);
    #1;
    {req_i, mode_i, addr_i, wr_i, wdata_i} = {1'b1, m, a, w, d};
    @(posedge core_clk_i);
    #1;
    req_i = 0;
    check("xen", {7'h00, xen}, {7'h00, p});
    for (k = 0; k < 9 && done_o !== 1'b1; k++) @(posedge core_clk_i) #1;
    if (k == 9) begin
      bad_count++;
      hung = 1;
      return;
    end
    if (!w || t == 3) case (m)
      0: check("reg", rdata_o, e);
      1: check("dir", rdata_o, e);
      2: check("ind", rdata_o, e);
      3: check("imm", rdata_o, e);
      4: check("bit", rdata_o, e);
      7: check("code", rdata_o, e);
      default: check("ext", rdata_o, e);
    endcase
  endtask
  // Disabled extended RAM first, then preload, then random traffic
  initial begin
    logic [2:0] m;
    logic [15:0] a;
    void'($urandom(38947));
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_i = 0;
    check("xen", {7'h00, xen}, 8'h00);
    op(3'h6, 16'h0011, 1, 8'hC3);
    op(3'h6, 16'h0011, 0, 8'h00);
    op(3'h1, 16'h00AF, 1, 8'h01);
    for (int i = 0; i < 256; i++) begin
      op(3'h2, 16'(i), 1, 8'(i * 7));
      op(3'h5, 16'(i), 1, 8'(~i));
    end
    // Mid-run reset: one idle edge first so no far-side write is cut off
    @(posedge core_clk_i);
    #1;
    rst_i = 1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 0;
    cfg = 0;
    check("xen", {7'h00, xen}, 8'h00);
    // Re-enable through the upper bit alone
    op(3'h1, 16'h00AF, 1, 8'h02);
    repeat (600) begin
      m = 3'($urandom);
      a = 16'($urandom);
      if (a[0]) a[15:8] = 8'h00;
      if (m == 1 && a[1] && a[2]) a = 16'h00AF;
      {bhi, blo} = 2'($urandom);
      op(m, a, 1'($urandom), 8'($urandom));
    end
    conclude;
  end
endmodule // core_data_memory_space_decoder_tb
`default_nettype wire
